// >>> include/smme_pkg.sv
/*
  Package of the script memory move engine: instruction field layout, register window
  indices, timing counts, reset values and the state encoding.
  Assumes a single host bus clock and byte addressing on the system bus.
*/
package smme_pkg;

  // ****************************************
  // instruction fields
  // ****************************************
  localparam int OP_HI = 31;
  localparam int OP_LO = 30;
  localparam int RSVD_HI = 29;
  localparam int RSVD_LO = 24;
  localparam int CNT_HI = 23;
  localparam int CNT_LO = 0;
  localparam logic [1:0] MOVE_OPCODE = 2'h3;

  // ****************************************
  // checks and sizes
  // ****************************************
  localparam logic [23:0] LINE_CHECK_BYTES = 24'h20;
  localparam logic [31:0] WORD_BYTES = 32'h4;
  localparam logic [1:0] LAST_FETCH_WORD = 2'h2;

  // ****************************************
  // register window
  // ****************************************
  localparam int REG_SEL_W = 7;
  localparam logic [6:0] FBR_INDEX = 7'h08;

  // ****************************************
  // timing and reset values
  // ****************************************
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [31:0] RESET_PTR = 32'h0;
  localparam logic [7:0] RESET_FBR = 8'h0;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    SMME_IDLE   = 3'h0,
    SMME_FETCH  = 3'h1,
    SMME_DECODE = 3'h3,
    SMME_READ   = 3'h2,
    SMME_WRITE  = 3'h6,
    SMME_DONE   = 3'h7,
    SMME_HALT   = 3'h5
  } smme_state_t;

endpackage

// >>> include/smme_fifo_if.sv
/*
  Interface between the move sequencer and its burst buffer memory.
  Assumes both ends run on the same clock; read data arrive one cycle after the address.
*/
`timescale 1ns/1ns

interface smme_fifo_if #(
  parameter int DW = 32,
  parameter int AW = 3
);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;

  modport ctl (
    output wrEn,
    output wrAddr,
    output wrData,
    output rdAddr,
    input rdData
  );

  modport mem (
    input wrEn,
    input wrAddr,
    input wrData,
    input rdAddr,
    output rdData
  );
endinterface

// >>> rtl/smme_sync.sv
/*
  Two flip-flop synchroniser for a level coming from a pin.
  Assumes the input may change at any time relative to ref_clk.
*/
`timescale 1ns/1ns

module smme_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // level in and out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } smme_sync_t;

  smme_sync_t st;
  smme_sync_t next_st;

  always_comb
  begin
    next_st.meta = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= {RESET_VAL, RESET_VAL};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule

// >>> rtl/smme_fifo_mem.sv
/*
  Burst buffer memory of the move engine, one word per bus beat.
  Assumes the writer takes the old word when it reads and writes the same word in one cycle.
*/
`timescale 1ns/1ns

module smme_fifo_mem #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // buffer access
  smme_fifo_if.mem port
);

  logic [31:0] words [DEPTH];
  logic [31:0] rdReg;

  // ****************************************
  // storage, no reset on data
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (port.wrEn)
    begin
      words[port.wrAddr] <= port.wrData;
    end
  end

  // ****************************************
  // registered read
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdReg <= 32'h0;
    end
    else
    begin
      rdReg <= words[port.rdAddr];
    end
  end

  assign port.rdData = rdReg;

endmodule

// >>> rtl/smme_engine.sv
/*
  Memory move engine of the script processor: fetches a three word move instruction,
  checks it, and copies the byte count from source to destination in buffered bursts.
  Assumes a same-clock system bus with a one-cycle acknowledge and an external address
  decode that drives the register window chip select on a pin.
*/
// Summary of operation
// - copy exactly the instruction byte count; at most 16 MB per instruction.
// - source and destination address bits 1..0 differ gives illegal instruction, no move.
// - line bursting on and count above 32 needs address bits 3..0 equal.
// - only direct absolute addresses; the fetched words are the addresses themselves.
// - move in bursts: read source into the buffer, then write it out.
// - count down remaining bytes until zero, then fetch the next instruction.
// - saved script pointer and data structure address hold the running addresses.
// - bits 31..30 of the first word identify a memory move.
// - nonzero bits 29..24 of the first word give illegal instruction.
// - byte count is bits 23..0 of the first word.
// - second word is the 32-bit absolute source start address.
// - third word is the 32-bit absolute destination start address.
// - chip select may rise during our own move cycles; accept it.
// - with chip select, register at low seven address bits is source or destination.
// - first byte received register ignores writes from the register window.
// - register window moves get the same alignment checks as memory moves.
// - a raised interrupt drives the active low interrupt request output.
`timescale 1ns/1ns

module smme_engine #(
  parameter int BURST = 8,
  parameter logic [1:0] MOVE_OP = smme_pkg::MOVE_OPCODE
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // script control
  input wire logic startPtrWr,
  input wire logic [31:0] startPtr,
  input wire logic cacheBurstEn,
  input wire logic fbrLoad,
  input wire logic [7:0] fbrData,
  // system bus master
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [3:0] memBe,
  output logic [31:0] memWdata,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  // register window
  input wire logic chipSelN,
  output logic [6:0] regSel,
  output logic regWr,
  output logic regRd,
  output logic [31:0] regWdata,
  output logic [3:0] regBe,
  input wire logic [31:0] regRdata,
  // status
  output logic irqN,
  output logic illegalInsn,
  output logic busy,
  output logic [31:0] scriptPtr,
  output logic [31:0] savedScriptPtr,
  output logic [31:0] dataStructAddr,
  output logic [23:0] remainCount,
  output logic [7:0] firstByteReceived,
  output logic foreignValid,
  output logic [31:0] foreignInsn
);

  localparam int AW = $clog2(BURST);
  localparam int IDXW = AW + 1;

  typedef struct packed {
    smme_pkg::smme_state_t state;
    logic [31:0] scriptPtr;
    logic [31:0] insn;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] addr;
    logic [23:0] remain;
    logic [23:0] readRem;
    logic [IDXW-1:0] beatIdx;
    logic [IDXW-1:0] rdBeats;
    logic [1:0] fetchIdx;
    logic [1:0] settle;
    logic [3:0] be;
    logic [2:0] beatN;
    logic irqFlag;
    logic [7:0] fbr;
    logic foreign;
  } smme_eng_t;

  smme_eng_t st;
  smme_eng_t next_st;

  logic csSyncN;
  logic accessPhase;
  logic regHit;
  logic isFbr;
  logic beatDone;
  logic [31:0] readWord;
  logic [23:0] moveCount;
  logic rsvdBad;
  logic alignBad;
  logic lineBad;

  smme_fifo_if #(.DW(32), .AW(AW)) fifoBus ();

  // ****************************************
  // bytes and lanes of one beat
  // ****************************************
  function automatic logic [6:0] beatCalc(input logic [1:0] off, input logic [23:0] rem);
    logic [2:0] avail;
    logic [2:0] n;
    logic [3:0] mask;
    avail = 3'h4 - {1'h0, off};
    n = (rem < {21'h0, avail}) ? rem[2:0] : avail;
    mask = 4'((5'h1 << n) - 5'h1);
    return {4'(mask << off), n};
  endfunction

  // ****************************************
  // chip select pin and submodules
  // ****************************************
  smme_sync #(.W(1), .RESET_VAL(1'h1)) csSync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din(chipSelN),
    .dout(csSyncN)
  );

  smme_fifo_mem #(.DEPTH(BURST)) burstBuf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .port(fifoBus.mem)
  );

  // ****************************************
  // beat decode
  // ****************************************
  assign accessPhase = ((st.state == smme_pkg::SMME_READ) || (st.state == smme_pkg::SMME_WRITE))
                       && (st.settle == 2'h0);
  assign regHit = accessPhase && !csSyncN;
  assign isFbr = (st.addr[smme_pkg::REG_SEL_W-1:0] == smme_pkg::FBR_INDEX);
  assign beatDone = regHit || (accessPhase && memAck);
  assign readWord = regHit ? (isFbr ? {4{st.fbr}} : regRdata) : memRdata;

  assign moveCount = st.insn[smme_pkg::CNT_HI:smme_pkg::CNT_LO];
  assign rsvdBad = |st.insn[smme_pkg::RSVD_HI:smme_pkg::RSVD_LO];
  // checks use the fetched addresses whatever they decode to
  assign alignBad = (st.src[1:0] != st.dst[1:0]);
  assign lineBad = cacheBurstEn && (moveCount > smme_pkg::LINE_CHECK_BYTES)
                   && (st.src[3:0] != st.dst[3:0]);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    logic [31:0] nSrc;
    logic [31:0] nDst;
    logic [23:0] nRead;
    logic [23:0] nRemain;
    nSrc = st.src + {29'h0, st.beatN};
    nDst = st.dst + {29'h0, st.beatN};
    nRead = st.readRem - {21'h0, st.beatN};
    nRemain = st.remain - {21'h0, st.beatN};
    next_st = st;
    next_st.foreign = 1'h0;
    if (fbrLoad)
      next_st.fbr = fbrData;
    if (st.settle != 2'h0)
      next_st.settle = st.settle - 2'h1;
    case (st.state)
      smme_pkg::SMME_IDLE, smme_pkg::SMME_HALT:
      begin
        if (startPtrWr)
        begin
          next_st.scriptPtr = startPtr;
          next_st.addr = startPtr;
          next_st.fetchIdx = 2'h0;
          next_st.irqFlag = 1'h0;
          next_st.state = smme_pkg::SMME_FETCH;
        end
      end
      smme_pkg::SMME_FETCH:
      begin
        if (memAck)
        begin
          next_st.scriptPtr = st.scriptPtr + smme_pkg::WORD_BYTES;
          next_st.addr = st.addr + smme_pkg::WORD_BYTES;
          next_st.fetchIdx = st.fetchIdx + 2'h1;
          if (st.fetchIdx == 2'h0)
          begin
            next_st.insn = memRdata;
            if (memRdata[smme_pkg::OP_HI:smme_pkg::OP_LO] != MOVE_OP)
            begin
              next_st.foreign = 1'h1;
              next_st.state = smme_pkg::SMME_IDLE;
            end
          end
          else if (st.fetchIdx == 2'h1)
            next_st.src = memRdata;
          else
          begin
            next_st.dst = memRdata;
            next_st.state = smme_pkg::SMME_DECODE;
          end
        end
      end
      smme_pkg::SMME_DECODE:
      begin
        next_st.remain = moveCount;
        next_st.readRem = moveCount;
        next_st.beatIdx = '0;
        next_st.rdBeats = '0;
        next_st.addr = st.src;
        next_st.settle = smme_pkg::SETTLE_CYCLES;
        {next_st.be, next_st.beatN} = beatCalc(st.src[1:0], moveCount);
        if (rsvdBad || alignBad || lineBad)
        begin
          next_st.irqFlag = 1'h1;
          next_st.state = smme_pkg::SMME_HALT;
        end
        else if (moveCount == 24'h0)
          next_st.state = smme_pkg::SMME_DONE;
        else
          next_st.state = smme_pkg::SMME_READ;
      end
      smme_pkg::SMME_READ:
      begin
        if (beatDone)
        begin
          next_st.src = nSrc;
          next_st.readRem = nRead;
          next_st.beatIdx = st.beatIdx + 1'h1;
          next_st.rdBeats = st.rdBeats + 1'h1;
          next_st.settle = smme_pkg::SETTLE_CYCLES;
          if ((nRead == 24'h0) || (st.beatIdx == IDXW'(BURST - 1)))
          begin
            next_st.state = smme_pkg::SMME_WRITE;
            next_st.beatIdx = '0;
            next_st.addr = st.dst;
            {next_st.be, next_st.beatN} = beatCalc(st.dst[1:0], st.remain);
          end
          else
          begin
            next_st.addr = nSrc;
            {next_st.be, next_st.beatN} = beatCalc(nSrc[1:0], nRead);
          end
        end
      end
      smme_pkg::SMME_WRITE:
      begin
        if (beatDone)
        begin
          next_st.dst = nDst;
          next_st.remain = nRemain;
          next_st.beatIdx = st.beatIdx + 1'h1;
          next_st.settle = smme_pkg::SETTLE_CYCLES;
          if ((st.beatIdx + 1'h1) == st.rdBeats)
          begin
            next_st.state = (nRemain == 24'h0) ? smme_pkg::SMME_DONE : smme_pkg::SMME_READ;
            next_st.beatIdx = '0;
            next_st.rdBeats = '0;
            next_st.addr = st.src;
            {next_st.be, next_st.beatN} = beatCalc(st.src[1:0], st.readRem);
          end
          else
          begin
            next_st.addr = nDst;
            {next_st.be, next_st.beatN} = beatCalc(nDst[1:0], nRemain);
          end
        end
      end
      smme_pkg::SMME_DONE:
      begin
        next_st.addr = st.scriptPtr;
        next_st.fetchIdx = 2'h0;
        next_st.state = smme_pkg::SMME_FETCH;
      end
      default:
        next_st.state = smme_pkg::SMME_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.state <= smme_pkg::SMME_IDLE;
      st.scriptPtr <= smme_pkg::RESET_PTR;
      st.fbr <= smme_pkg::RESET_FBR;
    end
    else
      st <= next_st;
  end

  // ****************************************
  // burst buffer access
  // ****************************************
  assign fifoBus.wrEn = (st.state == smme_pkg::SMME_READ) && beatDone;
  assign fifoBus.wrAddr = st.beatIdx[AW-1:0];
  assign fifoBus.wrData = readWord;
  assign fifoBus.rdAddr = st.beatIdx[AW-1:0];

  // ****************************************
  // outputs
  // ****************************************
  assign memReq = (st.state == smme_pkg::SMME_FETCH) || (accessPhase && csSyncN);
  assign memWe = (st.state == smme_pkg::SMME_WRITE);
  assign memAddr = st.addr;
  assign memBe = (st.state == smme_pkg::SMME_FETCH) ? 4'hf : st.be;
  assign memWdata = fifoBus.rdData;
  assign regSel = st.addr[smme_pkg::REG_SEL_W-1:0];
  assign regWr = regHit && (st.state == smme_pkg::SMME_WRITE) && !isFbr;
  assign regRd = regHit && (st.state == smme_pkg::SMME_READ);
  assign regWdata = fifoBus.rdData;
  assign regBe = st.be;
  assign irqN = !st.irqFlag;
  assign illegalInsn = st.irqFlag;
  assign busy = (st.state != smme_pkg::SMME_IDLE) && (st.state != smme_pkg::SMME_HALT);
  assign scriptPtr = st.scriptPtr;
  assign savedScriptPtr = st.src;
  assign dataStructAddr = st.dst;
  assign remainCount = st.remain;
  assign firstByteReceived = st.fbr;
  assign foreignValid = st.foreign;
  assign foreignInsn = st.insn;

endmodule

// >>> verif/smme_mem_model.sv
/*
  System memory model on the far side of the move engine bus.
  Assumes one clock; acknowledge is a one-cycle pulse while the request is held.
*/
`timescale 1ns/1ns

module smme_mem_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // system bus
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [3:0] memBe,
  input wire logic [31:0] memWdata,
  output logic [31:0] memRdata,
  output logic memAck,
  // pacing
  input wire logic slow
);
  logic [31:0] mem [0:255];
  logic [1:0] dly;
  logic [3:0] cyc;

  // read data only valid with acknowledge, a moving pattern otherwise
  assign memRdata = memAck ? mem[memAddr[9:2]] : {8{cyc}};

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memAck <= 1'b0;
      dly <= 2'h0;
      cyc <= 4'h0;
    end
    else
    begin
      cyc <= cyc + 4'h1;
      memAck <= 1'b0;
      if (memReq && !memAck)
      begin
        if (dly == (slow ? 2'h2 : 2'h0))
        begin
          memAck <= 1'b1;
          dly <= 2'h0;
        end
        else
          dly <= dly + 2'h1;
      end
      if (memReq && memAck && memWe)
        for (int b = 0; b < 4; b++)
          if (memBe[b])
            mem[memAddr[9:2]][8*b +: 8] <= memWdata[8*b +: 8];
    end
  end
endmodule

// >>> verif/smme_engine_sva.sv
/*
  Checker of the move engine, watching top module ports only.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ns

module smme_engine_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // observed ports
  input wire logic startPtrWr,
  input wire logic [31:0] startPtr,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [3:0] memBe,
  input wire logic memAck,
  input wire logic [6:0] regSel,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic irqN,
  input wire logic illegalInsn,
  input wire logic busy,
  input wire logic [23:0] remainCount,
  input wire logic foreignValid,
  input wire logic [31:0] foreignInsn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_beat_wait;
    memReq && !memAck;
  endsequence
  sequence s_beat_held;
    memReq && $stable(memAddr) && $stable(memWe);
  endsequence

  a_beat_held:
    assert property (s_beat_wait |=> s_beat_held) else $error("request changed before acknowledge");
  a_start_fetch:
    assert property (startPtrWr && !busy |=> busy && memReq && !memWe && memAddr == $past(startPtr))
    else $error("script start did not fetch at new pointer");
  a_irq_level:
    assert property (irqN == !illegalInsn) else $error("interrupt pin disagrees with flag");
  a_halt_quiet:
    assert property (!irqN |-> !memReq && !regWr && !regRd) else $error("bus activity while halted");
  a_fbr_guard:
    assert property (regWr |-> regSel != smme_pkg::FBR_INDEX) else $error("write to first byte register");
  a_reg_select:
    assert property ((regWr || regRd) |-> regSel == memAddr[6:0] && !memReq) else $error("bad register select");
  a_count_down:
    assert property (memReq && memWe && memAck |=> remainCount == $past(remainCount) - 24'($countones($past(memBe))))
    else $error("remaining count not reduced by beat bytes");
  a_foreign_op:
    assert property (foreignValid |-> foreignInsn[31:30] != smme_pkg::MOVE_OPCODE) else $error("move passed on as foreign");
  a_idle_quiet:
    assert property (!busy |-> !memReq && !regWr && !regRd) else $error("bus activity while idle");
  a_irq_after_fetch:
    assert property ($fell(irqN) |-> $past(memAck, 2) && !$past(memWe, 2) && !$past(memReq))
    else $error("interrupt raised without a fresh instruction fetch");
endmodule

bind smme_engine smme_engine_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n), .startPtrWr(startPtrWr),
  .startPtr(startPtr), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memBe(memBe), .memAck(memAck),
  .regSel(regSel), .regWr(regWr), .regRd(regRd), .irqN(irqN), .illegalInsn(illegalInsn), .busy(busy),
  .remainCount(remainCount), .foreignValid(foreignValid), .foreignInsn(foreignInsn));

// >>> verif/tb_script_memory_move_engine.sv
/*
  Self-checking bench of the move engine with a memory model and register window.
  Assumes a 100 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/1ns

module tb_script_memory_move_engine;
  typedef struct packed {logic [31:0] w0; logic [31:0] src; logic [31:0] dst; logic cbe; logic slow; logic ill;} smme_row_t;
  logic ref_clk = 1'b0, arst_n = 1'b0, startPtrWr = 1'b0, cacheBurstEn = 1'b0, fbrLoad = 1'b0, slow = 1'b0;
  logic [31:0] startPtr = 32'h0, memRdata, memAddr, memWdata, regWdata, regRdata, scriptPtr, lastData;
  logic [7:0] fbrData = 8'h00, firstByteReceived;
  logic [31:0] savedScriptPtr, dataStructAddr, foreignInsn, lastForeign;
  logic memReq, memWe, memAck, chipSelN, regWr, regRd, irqN, busy, foreignValid;
  logic [3:0] memBe, regBe, lastBe;
  logic [6:0] regSel, lastSel;
  logic [23:0] remainCount;
  int err_count = 0, samples_checked = 0, wrCount = 0, fgnCount = 0, good = 0;
  smme_row_t rows [8] = '{
    '{32'hc0000006, 32'h102, 32'h202, 1'b0, 1'b0, 1'b0}, '{32'hc0000000, 32'h100, 32'h200, 1'b0, 1'b1, 1'b0},
    '{32'hc0000028, 32'h100, 32'h200, 1'b1, 1'b1, 1'b0}, '{32'hc0000004, 32'h101, 32'h202, 1'b0, 1'b0, 1'b1},
    '{32'hc1000004, 32'h100, 32'h200, 1'b0, 1'b0, 1'b1}, '{32'hc0000021, 32'h104, 32'h208, 1'b1, 1'b0, 1'b1},
    '{32'hc0000020, 32'h104, 32'h208, 1'b1, 1'b1, 1'b0}, '{32'hc0000021, 32'h104, 32'h208, 1'b0, 1'b0, 1'b0}};

  always #5 ref_clk = ~ref_clk;
  assign chipSelN = !(memAddr[31:7] == 25'h1000000);
  assign regRdata = {4{1'b1, regSel}};

  always @(posedge ref_clk)
  begin
    if (regWr)
    begin
      wrCount <= wrCount + 1;
      lastSel <= regSel;
      lastData <= regWdata;
      lastBe <= regBe;
    end
    if (foreignValid)
    begin
      fgnCount <= fgnCount + 1;
      lastForeign <= foreignInsn;
    end
  end

  smme_engine DUT (.ref_clk(ref_clk), .arst_n(arst_n), .startPtrWr(startPtrWr), .startPtr(startPtr),
    .cacheBurstEn(cacheBurstEn), .fbrLoad(fbrLoad), .fbrData(fbrData), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memBe(memBe), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
    .chipSelN(chipSelN), .regSel(regSel), .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regBe(regBe),
    .regRdata(regRdata), .irqN(irqN), .illegalInsn(), .busy(busy), .scriptPtr(scriptPtr),
    .savedScriptPtr(savedScriptPtr), .dataStructAddr(dataStructAddr), .remainCount(remainCount),
    .firstByteReceived(firstByteReceived), .foreignValid(foreignValid), .foreignInsn(foreignInsn));
  smme_mem_model mdl (.ref_clk(ref_clk), .arst_n(arst_n), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memBe(memBe), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .slow(slow));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] mb(input logic [31:0] a);
    return mdl.mem[a[9:2]][8*a[1:0] +: 8];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic go(input logic [31:0] w0, input logic [31:0] src, input logic [31:0] dst, input logic cbe);
    mdl.mem[startPtr[9:2]] = w0;
    mdl.mem[startPtr[9:2] + 8'h1] = src;
    mdl.mem[startPtr[9:2] + 8'h2] = dst;
    mdl.mem[startPtr[9:2] + 8'h3] = 32'h40000055;
    for (int j = 128; j < 192; j++)
      mdl.mem[j] = 32'h0;
    cacheBurstEn = cbe;
    @(negedge ref_clk) startPtrWr = 1'b1;
    @(negedge ref_clk) startPtrWr = 1'b0;
  endtask

  task automatic run(input logic [31:0] w0, input logic [31:0] src, input logic [31:0] dst, input logic cbe);
    int n;
    go(w0, src, dst, cbe);
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    if (n == 3000)
    begin
      err_count++;
      finish_test;
    end
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (50000) @(posedge ref_clk);
    err_count++;
    finish_test;
  end

  initial
  begin
    for (int j = 0; j < 256; j++)
      mdl.mem[j] = {4{j[7:0]}} + 32'h03020100;
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    foreach (rows[r])
    begin
      int moved;
      moved = rows[r].ill ? 0 : int'(rows[r].w0[23:0]);
      slow = rows[r].slow;
      run(rows[r].w0, rows[r].src, rows[r].dst, rows[r].cbe);
      good += int'(!rows[r].ill);
      check(irqN, !rows[r].ill);
      if (!rows[r].ill)
        check(scriptPtr, 32'h10);
      check(fgnCount, good);
      check(lastForeign, 32'h40000055);
      check(savedScriptPtr, rows[r].src + moved);
      check(dataStructAddr, rows[r].dst + moved);
      for (int i = 0; i <= moved; i++)
        check(mb(rows[r].dst + i), i < moved ? mb(rows[r].src + i) : 8'h00);
    end
    // register window as source, first byte register read back
    @(negedge ref_clk) fbrLoad = 1'b1;
    fbrData = 8'ha5;
    @(negedge ref_clk) fbrLoad = 1'b0;
    run(32'hc0000008, 32'h80000008, 32'h208, 1'b0);
    check(mdl.mem[130], 32'ha5a5a5a5);
    check(mdl.mem[131], 32'h8c8c8c8c);
    // register window as destination, first byte register protected
    run(32'hc0000008, 32'h100, 32'h80000008, 1'b0);
    check(wrCount, 1);
    check(lastSel, 7'h0c);
    check(lastData, mdl.mem[65]);
    check(lastBe, 4'hf);
    check(firstByteReceived, 8'ha5);
    run(32'hc0000008, 32'h80000009, 32'h208, 1'b0);
    check(irqN, 1'b0);
    // reset in mid-move
    go(32'hc0000028, 32'h100, 32'h200, 1'b0);
    repeat (15) @(negedge ref_clk);
    arst_n = 1'b0;
    @(negedge ref_clk);
    check({busy, memReq, irqN}, 3'b001);
    arst_n = 1'b1;
    startPtr = 32'h40;
    run(32'hc0000004, 32'h100, 32'h200, 1'b0);
    check(mdl.mem[128], mdl.mem[64]);
    check(scriptPtr, 32'h50);
    finish_test;
  end
endmodule
